// File: rtl/acc_top.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module acc_top #(
  parameter int NPINS = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic alternate_clock,
  input wire logic internal_async_clock,
  input wire logic hw_trigger_input,
  input wire logic low_power_hold,
  input wire logic [acc_pkg::RAW_W-1:0] sar_result,
  output logic converter_clock,
  output logic sar_sample,
  output logic sar_active,
  output logic async_clock_run,
  output logic complete_irq,
  output logic [NPINS-1:0] pin_hiz,
  output logic [NPINS-1:0] pin_input_off,
  output logic [NPINS-1:0] pin_pullup_off
);
  // Elaboration guard: the three override banks are fixed at 8 bits each
  if (NPINS != 24) begin : g_npins_check
    $error("acc_top: NPINS must be 24");
  end

  // Sequencer state type, named before the record that holds it
  typedef acc_pkg::acc_state_t acc_state_t;

  // Module state in one record, rdata, ck_out and irq included; the pin override and status output flops are kept apart
  typedef struct packed {
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic [7:0] cfg;
    logic [7:0] cvh;
    logic [7:0] cvl;
    logic [7:0] resh;
    logic [7:0] resl;
    logic [7:0] pin_low;
    logic [7:0] analog_pin_override_mid;
    logic [7:0] analog_pin_override_high;
    logic [7:0] rdata;
    logic hi_read;
    logic [2:0] div_cnt;
    logic half_tgl;
    logic [1:0] alt_sync;
    logic [1:0] async_sync;
    logic [1:0] trig_sync;
    logic alt_prev;
    logic async_prev;
    logic trig_prev;
    logic [4:0] cyc;
    acc_state_t st;
    logic cont_run;
    logic ck_out;
    logic irq;
  } acc_st_t;

  acc_st_t s_reg;
  acc_st_t s_next;

  // Decoded fields
  logic [1:0] mode;
  logic [1:0] clk_sel;
  logic [1:0] div_sel;
  logic [4:0] chan;
  logic src_tick;
  logic converter_clock_tick;
  logic trig_rise;
  logic [2:0] div_mask;
  logic [12:0] rnd10;
  logic [9:0] rnd8;
  logic [11:0] fmt;
  logic [11:0] cmpv;
  logic cmp_true;
  logic [11:0] diff;
  logic cont;
  logic sw_start;
  logic blocked;

  assign mode = s_reg.cfg[acc_pkg::CFG_MODE_LSB +: 2];
  assign clk_sel = s_reg.cfg[acc_pkg::CFG_CLK_LSB +: 2];
  assign div_sel = s_reg.cfg[acc_pkg::CFG_DIV_LSB +: 2];
  assign chan = s_reg.sc1[acc_pkg::SC1_CH_LSB +: acc_pkg::CH_W];
  assign cont = s_reg.sc1[acc_pkg::SC1_CONT];

  // Source tick per selected clock; alternate and async are pin clocks
  // sampled through two flops, so they must run below half of clk
  always_comb begin
    case (clk_sel)
      acc_pkg::CLK_BUS: src_tick = 1'b1;
      acc_pkg::CLK_BUS_HALF: src_tick = s_reg.half_tgl;
      acc_pkg::CLK_ALT: src_tick = s_reg.alt_sync[1] & ~s_reg.alt_prev;
      default: src_tick = s_reg.async_sync[1] & ~s_reg.async_prev;
    endcase
  end

  // Divide ratio as a counter mask
  always_comb begin
    case (div_sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end
  assign converter_clock_tick = src_tick && ((s_reg.div_cnt & div_mask) == div_mask);

  // Trigger edge after synchroniser
  assign trig_rise = s_reg.trig_sync[1] & ~s_reg.trig_prev;

  // Result formatting and rounding
  always_comb begin
    rnd10 = {1'b0, sar_result} + 13'h0002;
    rnd8 = {1'b0, sar_result[11:3]} + 10'h001;
    case (mode)
      acc_pkg::MODE_12: fmt = sar_result;
      acc_pkg::MODE_10: fmt = rnd10[12] ? 12'h3FF : {2'h0, rnd10[11:2]};
      default: fmt = rnd8[9] ? 12'h0FF : {4'h0, rnd8[8:1]};
    endcase
  end

  // Compare against the programmed value in the active width
  always_comb begin
    case (mode)
      acc_pkg::MODE_12: cmpv = {s_reg.cvh[3:0], s_reg.cvl};
      acc_pkg::MODE_10: cmpv = {2'h0, s_reg.cvh[1:0], s_reg.cvl};
      default: cmpv = {4'h0, s_reg.cvl};
    endcase
    diff = fmt - cmpv;
    cmp_true = s_reg.sc2[acc_pkg::SC2_CMPGT] ? (fmt >= cmpv)
                                              : (fmt < cmpv);
  end

  // Interlock only outside 8-bit mode
  assign blocked = s_reg.hi_read &&
                   (mode != acc_pkg::MODE_8);
  assign sw_start = wr && (addr == acc_pkg::OFS_SC1) &&
                    (wdata[acc_pkg::SC1_CH_LSB +: acc_pkg::CH_W] !=
                     acc_pkg::CH_DISABLED);

  // Next-state logic: bus, clocking and conversion sequencing
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    s_next.alt_sync = {s_reg.alt_sync[0], alternate_clock};
    s_next.async_sync = {s_reg.async_sync[0], internal_async_clock};
    s_next.trig_sync = {s_reg.trig_sync[0], hw_trigger_input};
    s_next.alt_prev = s_reg.alt_sync[1];
    s_next.async_prev = s_reg.async_sync[1];
    s_next.trig_prev = s_reg.trig_sync[1];
    s_next.half_tgl = ~s_reg.half_tgl;
    if (src_tick) begin
      s_next.div_cnt = s_reg.div_cnt + 3'h1;
    end
    // Converter clock toggles only while converting, else held low
    if (s_reg.st == acc_pkg::ST_CONV && converter_clock_tick) begin
      s_next.ck_out = ~s_reg.ck_out;
      s_next.cyc = s_reg.cyc + 5'h01;
    end
    if (s_reg.st != acc_pkg::ST_CONV) begin
      s_next.ck_out = 1'b0;
    end

    // Conversion sequencer
    case (s_reg.st)
      acc_pkg::ST_IDLE: begin
        if (s_reg.sc2[acc_pkg::SC2_TRIG] && trig_rise &&
            chan != acc_pkg::CH_DISABLED) begin
          s_next.st = acc_pkg::ST_CONV;
          s_next.cyc = 5'h00;
          s_next.cont_run = cont;
        end
      end
      acc_pkg::ST_CONV: begin
        // Edges during conversion and continuous runs are dropped
        if (converter_clock_tick && s_reg.cyc == acc_pkg::CONV_CYCLES) begin
          s_next.st = acc_pkg::ST_DONE;
        end
      end
      default: begin
        // Transfer stage
        if (s_reg.sc2[acc_pkg::SC2_CMPEN] && !cmp_true) begin
          // Compare false: nothing transferred, blocking moot
          s_next.st = cont ? acc_pkg::ST_CONV : acc_pkg::ST_IDLE;
        end else if (blocked) begin
          s_next.st = acc_pkg::ST_CONV;
        end else begin
          if (s_reg.sc2[acc_pkg::SC2_CMPEN]) begin
            s_next.resh = {4'h0, diff[11:8]};
            s_next.resl = diff[7:0];
          end else begin
            s_next.resh = {4'h0, fmt[11:8]};
            s_next.resl = fmt[7:0];
          end
          s_next.sc1[acc_pkg::SC1_DONE] = 1'b1;
          s_next.st = cont ? acc_pkg::ST_CONV : acc_pkg::ST_IDLE;
        end
        s_next.cyc = 5'h00;
      end
    endcase
    if (s_reg.st == acc_pkg::ST_IDLE && s_reg.cont_run && !cont) begin
      s_next.cont_run = 1'b0;
    end

    // Register writes
    if (wr) begin
      if (addr == acc_pkg::OFS_SC1) begin
        s_next.sc1 = {1'b0, wdata[6:0]};
        s_next.st = acc_pkg::ST_IDLE;
        s_next.cyc = 5'h00;
        if (sw_start && !s_reg.sc2[acc_pkg::SC2_TRIG]) begin
          s_next.st = acc_pkg::ST_CONV;
        end
      end else if (addr == acc_pkg::OFS_SC2) begin
        s_next.sc2 = {1'b0, wdata[6:4], 4'h0};
        s_next.st = acc_pkg::ST_IDLE;
      end else if (addr == acc_pkg::OFS_CFG) begin
        s_next.cfg = wdata;
        s_next.st = acc_pkg::ST_IDLE;
      end else if (addr == acc_pkg::OFS_CVH) begin
        s_next.cvh = wdata;
        s_next.st = acc_pkg::ST_IDLE;
      end else if (addr == acc_pkg::OFS_CVL) begin
        s_next.cvl = wdata;
        s_next.st = acc_pkg::ST_IDLE;
      end else if (addr == acc_pkg::OFS_PIN_LOW) begin
        s_next.pin_low = wdata;
      end else if (addr == acc_pkg::OFS_PIN_MID) begin
        s_next.analog_pin_override_mid = wdata;
      end else if (addr == acc_pkg::OFS_PIN_HIGH) begin
        s_next.analog_pin_override_high = wdata;
      end
    end

    // Register reads; result reads drive the interlock
    if (rd) begin
      if (addr == acc_pkg::OFS_SC1) begin
        s_next.rdata = s_reg.sc1;
      end else if (addr == acc_pkg::OFS_SC2) begin
        s_next.rdata = {(s_reg.st != acc_pkg::ST_IDLE), s_reg.sc2[6:0]};
      end else if (addr == acc_pkg::OFS_RESH) begin
        s_next.rdata = s_reg.resh;
        s_next.hi_read = 1'b1;
      end else if (addr == acc_pkg::OFS_RESL) begin
        s_next.rdata = s_reg.resl;
        s_next.hi_read = 1'b0;
        // Reading the low byte acknowledges the result
        s_next.sc1[acc_pkg::SC1_DONE] = 1'b0;
      end else if (addr == acc_pkg::OFS_CVH) begin
        s_next.rdata = s_reg.cvh;
      end else if (addr == acc_pkg::OFS_CVL) begin
        s_next.rdata = s_reg.cvl;
      end else if (addr == acc_pkg::OFS_CFG) begin
        s_next.rdata = s_reg.cfg;
      end else if (addr == acc_pkg::OFS_PIN_LOW) begin
        s_next.rdata = s_reg.pin_low;
      end else if (addr == acc_pkg::OFS_PIN_MID) begin
        s_next.rdata = s_reg.analog_pin_override_mid;
      end else if (addr == acc_pkg::OFS_PIN_HIGH) begin
        s_next.rdata = s_reg.analog_pin_override_high;
      end
    end
    // A transfer in the same cycle as the acknowledge keeps the flag
    if (s_reg.st == acc_pkg::ST_DONE && s_next.sc1[acc_pkg::SC1_DONE] == 1'b0
        && !(wr && addr == acc_pkg::OFS_SC1) && !blocked &&
        !(s_reg.sc2[acc_pkg::SC2_CMPEN] && !cmp_true)) begin
      s_next.sc1[acc_pkg::SC1_DONE] = 1'b1;
    end

    // Disabled channel, or hold request unless the async source is selected, parks the converter
    if (s_next.sc1[acc_pkg::SC1_CH_LSB +: acc_pkg::CH_W] ==
        acc_pkg::CH_DISABLED) begin
      s_next.st = acc_pkg::ST_IDLE;
    end
    if (low_power_hold && clk_sel != acc_pkg::CLK_ASYNC) begin
      s_next.st = acc_pkg::ST_IDLE;
    end
    s_next.irq = s_next.sc1[acc_pkg::SC1_DONE] &&
                 s_next.sc1[acc_pkg::SC1_IRQEN];
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.sc1 <= acc_pkg::SC1_RESET;
      s_reg.st <= acc_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pin override and status outputs
  logic [NPINS-1:0] ovr_reg;
  logic sample_reg;
  logic active_reg;
  logic async_run_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovr_reg <= '0;
      sample_reg <= 1'b0;
      active_reg <= 1'b0;
      async_run_reg <= 1'b0;
    end else begin
      ovr_reg <= {s_next.analog_pin_override_high,
                  s_next.analog_pin_override_mid, s_next.pin_low};
      sample_reg <= (s_next.st == acc_pkg::ST_DONE);
      active_reg <= (s_next.st == acc_pkg::ST_CONV);
      async_run_reg <= (s_next.st == acc_pkg::ST_CONV) &&
                       (clk_sel == acc_pkg::CLK_ASYNC);
    end
  end

  assign rdata = s_reg.rdata;
  assign converter_clock = s_reg.ck_out;
  assign complete_irq = s_reg.irq;
  assign sar_sample = sample_reg;
  assign sar_active = active_reg;
  assign async_clock_run = async_run_reg;
  assign pin_hiz = ovr_reg;
  assign pin_input_off = ovr_reg;
  assign pin_pullup_off = ovr_reg;

  // Checks
  property p_irq_follows_flag;
    @(posedge clk) disable iff (!rstn)
      (s_reg.sc1[acc_pkg::SC1_DONE] && s_reg.sc1[acc_pkg::SC1_IRQEN])
        |-> complete_irq;
  endproperty
  a_irq_follows_flag: assert property (p_irq_follows_flag)
    else $error("irq missing with done flag");

  property p_disabled_idle;
    @(posedge clk) disable iff (!rstn)
      (chan == acc_pkg::CH_DISABLED) |-> (s_reg.st == acc_pkg::ST_IDLE);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("converter active with channel disabled");

  property p_block_no_flag;
    @(posedge clk) disable iff (!rstn)
      (s_reg.st == acc_pkg::ST_DONE && blocked && !rd && !wr &&
       !s_reg.sc1[acc_pkg::SC1_DONE] && !s_reg.sc2[acc_pkg::SC2_CMPEN])
        |=> (!s_reg.sc1[acc_pkg::SC1_DONE] && s_reg.st == acc_pkg::ST_CONV);
  endproperty
  a_block_no_flag: assert property (p_block_no_flag)
    else $error("blocked transfer set the flag");

  property p_sw_start;
    @(posedge clk) disable iff (!rstn)
      (sw_start && !s_reg.sc2[acc_pkg::SC2_TRIG] && !low_power_hold)
        |=> (s_reg.st == acc_pkg::ST_CONV);
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software write did not start");

  property p_abort;
    @(posedge clk) disable iff (!rstn)
      (wr && addr == acc_pkg::OFS_CFG) |=> (s_reg.st == acc_pkg::ST_IDLE);
  endproperty
  a_abort: assert property (p_abort)
    else $error("config write did not abort");

  property p_pins;
    @(posedge clk) disable iff (!rstn)
      (wr && addr == acc_pkg::OFS_PIN_MID) |=> (pin_hiz[15:8] == $past(wdata));
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin override not applied");

  property p_clock_idle;
    @(posedge clk) disable iff (!rstn)
      (s_reg.st == acc_pkg::ST_IDLE) |=> !converter_clock;
  endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("converter clock runs while idle");

  property p_trig_ignored;
    @(posedge clk) disable iff (!rstn)
      (s_reg.st == acc_pkg::ST_CONV && trig_rise && !wr && !low_power_hold
       && !(converter_clock_tick && s_reg.cyc == acc_pkg::CONV_CYCLES))
        |=> (s_reg.cyc == $past(s_reg.cyc) ||
             s_reg.cyc == $past(s_reg.cyc) + 5'h01);
  endproperty
  a_trig_ignored: assert property (p_trig_ignored)
    else $error("trigger restarted a conversion");
endmodule

// File: common/acc_pkg.sv
package acc_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [3:0] OFS_SC1 = 4'h0;
  localparam logic [3:0] OFS_SC2 = 4'h1;
  localparam logic [3:0] OFS_RESH = 4'h2;
  localparam logic [3:0] OFS_RESL = 4'h3;
  localparam logic [3:0] OFS_CVH = 4'h4;
  localparam logic [3:0] OFS_CVL = 4'h5;
  localparam logic [3:0] OFS_CFG = 4'h6;
  localparam logic [3:0] OFS_PIN_LOW = 4'h7;
  localparam logic [3:0] OFS_PIN_MID = 4'h8;
  localparam logic [3:0] OFS_PIN_HIGH = 4'h9;
  // Status-control one fields
  localparam int SC1_DONE = 7;
  localparam int SC1_IRQEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH_LSB = 0;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_DISABLED = 5'h1F;
  localparam logic [7:0] SC1_RESET = 8'h1F;
  // Status-control two fields
  localparam int SC2_BUSY = 7;
  localparam int SC2_TRIG = 6;
  localparam int SC2_CMPEN = 5;
  localparam int SC2_CMPGT = 4;
  // Configuration fields
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  // Resolution encodings
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  // Clock source encodings
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  // Raw result widths
  localparam int RAW_W = 12;
  localparam int RAW8_W = 9;
  // Last tick index of one conversion; 24 converter clock toggles in all
  localparam logic [4:0] CONV_CYCLES = 5'h17;
  // Conversion states
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} acc_state_t;
endpackage

// File: bench/acc_analog_model.sv
`timescale 1ns/1ps
// Far side: analog level seen by the converter, trigger source and
// the two foreign clocks that the block may pick as conversion source
module acc_analog_model (
  input wire logic clk,
  output logic [11:0] sar_result,
  output logic hw_trigger_input,
  output logic alternate_clock,
  output logic internal_async_clock
);
  // Quiet start, no trigger edge at time zero
  initial begin
    sar_result = 12'h000;
    hw_trigger_input = 1'b0;
    alternate_clock = 1'b0;
    internal_async_clock = 1'b0;
  end

  // Free running, both well under half the bus rate
  always #20 alternate_clock = ~alternate_clock;
  always #30 internal_async_clock = ~internal_async_clock;

  // New analog level, changed just after an edge
  task automatic set_level(input logic [11:0] lvl);
    @(posedge clk);
    sar_result <= lvl;
  endtask

  // Wide pulse so the synchroniser cannot miss the rising edge
  task automatic pulse_trigger();
    @(posedge clk);
    hw_trigger_input <= 1'b1;
    repeat (4) @(posedge clk);
    hw_trigger_input <= 1'b0;
  endtask
endmodule

// File: bench/acc_top_tb_top.sv
`timescale 1ns/1ps
module acc_top_tb_top;
  logic clk = 1'b0; // Bus clock
  logic rstn = 1'b0; // Reset, active low
  logic [3:0] addr = 4'h0; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic low_power_hold = 1'b0; // Stop request
  logic [7:0] rdata;
  logic [11:0] sar_result;
  logic hw_trigger_input, alternate_clock, internal_async_clock;
  logic converter_clock, sar_sample, sar_active;
  logic async_clock_run, complete_irq;
  logic [23:0] pin_hiz, pin_input_off, pin_pullup_off;
  int errors = 0;
  int comparisons = 0;
  int n;
  int t[4];
  logic [7:0] v; // Last read value

  always #5 clk = ~clk;

  acc_analog_model acc_analog_model_i (.clk(clk), .sar_result(sar_result),
    .hw_trigger_input(hw_trigger_input), .alternate_clock(alternate_clock),
    .internal_async_clock(internal_async_clock));

  acc_top acc_top_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alternate_clock(alternate_clock),
    .internal_async_clock(internal_async_clock),
    .hw_trigger_input(hw_trigger_input), .low_power_hold(low_power_hold),
    .sar_result(sar_result), .converter_clock(converter_clock),
    .sar_sample(sar_sample), .sar_active(sar_active),
    .async_clock_run(async_clock_run), .complete_irq(complete_irq),
    .pin_hiz(pin_hiz), .pin_input_off(pin_input_off),
    .pin_pullup_off(pin_pullup_off));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; idle cycle after so the strobe is never set twice
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Data is valid only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rreg(a);
    chk(v, e);
  endtask

  // Bounded wait for the transfer cycle, then let the result land
  task automatic conv(output int cyc);
    cyc = 0;
    while (sar_sample !== 1'b1 && cyc < 5000) begin
      @(posedge clk);
      cyc++;
    end
    chk(32'(cyc < 5000), 32'h1);
    repeat (3) @(posedge clk);
  endtask

  // Count transfer cycles over a window
  task automatic count_xfer(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (sar_sample === 1'b1) k++;
    end
  endtask

  // Set the level, pick the mode and start by software
  task automatic single(input logic [7:0] cfg, input logic [11:0] lvl);
    acc_analog_model_i.set_level(lvl);
    wreg(acc_pkg::OFS_CFG, cfg);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    conv(n);
  endtask

  // Single exit point for the run
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset state and the disabled channel code
    rchk(acc_pkg::OFS_SC1, acc_pkg::SC1_RESET);
    rchk(acc_pkg::OFS_CFG, 8'h00);
    rchk(4'hF, 8'h00);
    wreg(acc_pkg::OFS_SC1, 8'(acc_pkg::CH_DISABLED));
    repeat (40) @(posedge clk);
    chk(sar_active, 1'b0);
    chk(converter_clock, 1'b0);
    $display("test reset done");
    // Pin overrides, all three banks at once
    wreg(acc_pkg::OFS_PIN_LOW, 8'h81);
    wreg(acc_pkg::OFS_PIN_MID, 8'hA5);
    wreg(acc_pkg::OFS_PIN_HIGH, 8'h3C);
    chk(pin_hiz, 24'h3CA581);
    chk(pin_input_off, 24'h3CA581);
    chk(pin_pullup_off, 24'h3CA581);
    rchk(acc_pkg::OFS_PIN_MID, 8'hA5);
    $display("test pins done");
    // Results read only after completion
    acc_analog_model_i.set_level(12'hABC);
    wreg(acc_pkg::OFS_CFG, 8'h04);
    wreg(acc_pkg::OFS_SC1, 8'h40);
    conv(n);
    rchk(acc_pkg::OFS_SC1, 8'hC0);
    chk(complete_irq, 1'b1);
    chk(sar_active, 1'b0);
    rchk(acc_pkg::OFS_RESH, 8'h0A);
    rchk(acc_pkg::OFS_RESL, 8'hBC);
    chk(complete_irq, 1'b0);
    single(8'h08, 12'h3FE);
    rchk(acc_pkg::OFS_RESH, 8'h01);
    rchk(acc_pkg::OFS_RESL, 8'h00);
    // High byte read first: no interlock in this mode
    acc_analog_model_i.set_level(12'h0F8);
    wreg(acc_pkg::OFS_CFG, 8'h00);
    rreg(acc_pkg::OFS_RESH);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    conv(n);
    rchk(acc_pkg::OFS_SC1, 8'h80);
    rchk(acc_pkg::OFS_RESL, 8'h10);
    $display("test formats done");
    // Half-read result blocks the next transfer, which then retries
    single(8'h04, 12'h123);
    rchk(acc_pkg::OFS_RESH, 8'h01);
    acc_analog_model_i.set_level(12'h456);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    conv(n);
    rchk(acc_pkg::OFS_SC1, 8'h00);
    chk(sar_active, 1'b1);
    rchk(acc_pkg::OFS_RESL, 8'h23);
    conv(n);
    rchk(acc_pkg::OFS_RESH, 8'h04);
    rchk(acc_pkg::OFS_RESL, 8'h56);
    $display("test interlock done");
    // Compare below 0x100; false result with interlock armed stops
    wreg(acc_pkg::OFS_CVH, 8'h01);
    wreg(acc_pkg::OFS_CVL, 8'h00);
    wreg(acc_pkg::OFS_SC2, 8'h20);
    rreg(acc_pkg::OFS_RESH);
    single(8'h04, 12'h200);
    rchk(acc_pkg::OFS_SC1, 8'h00);
    chk(sar_active, 1'b0);
    rreg(acc_pkg::OFS_RESL);
    single(8'h04, 12'h050);
    rchk(acc_pkg::OFS_SC1, 8'h80);
    // Difference 0x050 - 0x100 lands in the result registers
    rchk(acc_pkg::OFS_RESH, 8'h0F);
    rchk(acc_pkg::OFS_RESL, 8'h50);
    wreg(acc_pkg::OFS_SC2, 8'h00);
    $display("test compare done");
    // Hardware trigger: no start on write, one per edge, busy ignores
    wreg(acc_pkg::OFS_SC2, 8'h40);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    repeat (40) @(posedge clk);
    chk(sar_active, 1'b0);
    acc_analog_model_i.pulse_trigger();
    repeat (6) @(posedge clk);
    acc_analog_model_i.pulse_trigger();
    count_xfer(1000, n);
    chk(n, 32'h1);
    wreg(acc_pkg::OFS_SC1, 8'h20);
    acc_analog_model_i.pulse_trigger();
    count_xfer(300, n);
    acc_analog_model_i.pulse_trigger();
    count_xfer(600, t[0]);
    chk(32'(n + t[0] > 2), 32'h1);
    wreg(acc_pkg::OFS_SC2, 8'h00);
    repeat (3) @(posedge clk);
    chk(sar_active, 1'b0);
    $display("test trigger done");
    // Each divide step must stretch the conversion
    for (int d = 0; d < 4; d++) begin
      wreg(acc_pkg::OFS_CFG, 8'(d << acc_pkg::CFG_DIV_LSB) | 8'h04);
      wreg(acc_pkg::OFS_SC1, 8'h00);
      conv(t[d]);
      if (d > 0) chk(32'(t[d] > t[d-1] + 20), 32'h1);
    end
    wreg(acc_pkg::OFS_CFG, 8'h05);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    conv(n);
    chk(32'(n > t[0] + 20), 32'h1);
    single(8'h06, 12'h111);
    // Async source keeps running through a stop request
    wreg(acc_pkg::OFS_CFG, 8'h07);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    repeat (4) @(posedge clk);
    chk(async_clock_run, 1'b1);
    low_power_hold <= 1'b1;
    conv(n);
    low_power_hold <= 1'b0;
    rchk(acc_pkg::OFS_SC1, 8'h80);
    // Stop request aborts when the source is the bus clock
    wreg(acc_pkg::OFS_CFG, 8'h04);
    wreg(acc_pkg::OFS_SC1, 8'h00);
    low_power_hold <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sar_active, 1'b0);
    chk(async_clock_run, 1'b0);
    low_power_hold <= 1'b0;
    $display("test clocks done");
    results();
  end
endmodule
